// ### logic/gcs_clock_ctrl.sv
// Global clock line source select, gate and PLL reference select.
// Assumes every clock source is a level sampled synchronously on aclk and
// that software configures over AXI4-Lite before entering user mode.
// Operation
// - Each line mux sees two pins, two PLL outputs, one logic; lines 0-9 also see one dual pin.
// - Run-time choice is only among the two pins and two PLL outputs.
// - User logic drives a two-bit dynamic select; the mux applies it.
// - Dual-purpose pin and internal logic sources are static choices only.
// - Static selection is set before user mode and locked afterwards.
// - A line's PLL outputs all come from the PLL on its own side.
// - PLL reference mux select is static or dynamic under manual switch.
// - Only lines sourced by pins or PLL outputs may feed a PLL input.
// - Ordinary I/O pins have no path to a PLL reference input.
// - Each PLL has five counter outputs; two are offered per line.
// - Twenty muxes, five per side, each driving its own clock line.
// - User logic enables or disables each line; disabled lines stay off.
// - Unused lines are powered down by static configuration bits.
// - Line power-down acts on the line alone, never on a PLL.
// - Pin pairs of group g reach lines 5g+k by the fixed pin pattern.
// - Four dual-purpose pins reach lines 0,2; 1,3,4; 5,7; 6,8,9.
// - Small parts have four pins on two sides; large ones eight.
// - Single-ended pins act alone; a differential pair acts as one.
// - The line enable is sampled on the selected clock's falling edge.
// - Gating a line leaves the PLL counters and lock untouched.
`timescale 1ns/100ps
`default_nettype none
`include "gcs_defs.svh"
module gcs_clock_ctrl
	import gcs_pkg::*;
#(
	parameter bit LARGE_DENSITY = 1'b1
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [`GCS_NPIN-1:0] ded_clk_p,
	input wire logic [`GCS_NPIN-1:0] ded_clk_n,
	input wire logic [3:0] dual_purpose_clock_pin,
	input wire logic [`GCS_NSIDE*`GCS_LPS-1:0] pll_counter_out,
	input wire logic [`GCS_NLINE-1:0] logic_clk_src,
	input wire logic [2*`GCS_NLINE-1:0] clk_select,
	input wire logic [`GCS_NLINE-1:0] clk_enable,
	input wire logic [2*`GCS_NSIDE-1:0] pll_clkswitch,
	output logic [`GCS_NLINE-1:0] global_clock_line,
	output logic [`GCS_NLINE-1:0] line_pll_ok,
	output logic [`GCS_NSIDE-1:0] pll_ref_clk
);

	gcs_state_t st_q;
	gcs_state_t st_d;
	logic [`GCS_NPIN-1:0] pin_p;
	logic [`GCS_NPIN-1:0] pin_n;
	logic [`GCS_NLINE-1:0] src_v;
	logic [`GCS_NLINE-1:0] fall_v;
	logic [`GCS_NLINE-1:0] quiet_v;
	logic [`GCS_NSIDE-1:0] ref_v;

	// Four-way dynamic mux; static sources never appear here.
	function automatic logic pick(input logic [1:0] s, input logic a,
		input logic b, input logic c, input logic d);
		case (s)
			2'h0: pick = a;
			2'h1: pick = b;
			2'h2: pick = c;
			default: pick = d;
		endcase
	endfunction

	function automatic logic [2:0] dp_index(input int i);
		case (i)
			0, 2: dp_index = 3'h0;
			1, 3, 4: dp_index = 3'h1;
			5, 7: dp_index = 3'h2;
			6, 8, 9: dp_index = 3'h3;
			default: dp_index = `GCS_NO_DUAL_PURPOSE_CLOCK_PIN;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		merge = r;
	endfunction

	function automatic logic [31:0] ctrl_word(input gcs_state_t s);
		logic [31:0] w;
		w = 32'h0;
		w[`GCS_CTRL_UMODE] = s.umode;
		w[`GCS_CTRL_DIFF +: 4] = s.diff;
		w[`GCS_CTRL_MANSW +: 4] = s.mansw;
		w[`GCS_CTRL_REFSEL +: 8] = s.refsel;
		ctrl_word = w;
	endfunction

	// Small parts have no pins on the top and bottom sides.
	for (genvar j = 0; j < `GCS_NPIN; j++)
	begin : g_pin
		if (LARGE_DENSITY || j < `GCS_SMALL_PINS)
		begin : g_on
			assign pin_p[j] = ded_clk_p[j];
			// In differential use the pair is one input seen on p.
			assign pin_n[j] = st_q.diff[j/2] ? ded_clk_p[j] : ded_clk_n[j];
		end
		else
		begin : g_off
			assign pin_p[j] = 1'b0;
			assign pin_n[j] = 1'b0;
		end
	end

	// Declared ahead of the per-line checks so that they share one clock
	// and are all held off while reset is applied.
	default clocking chk_clk @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	for (genvar i = 0; i < `GCS_NLINE; i++)
	begin : g_line
		localparam int G = i / `GCS_LPS;
		localparam int K = i % `GCS_LPS;
		logic ca;
		logic cb;
		logic pa;
		logic pb;
		logic dyn_cur;
		logic dyn_new;
		logic dpv;
		logic [2:0] ia;
		logic [2:0] ib;
		logic [2:0] dpi;
		logic [`GCS_LPS-1:0] cnt;
		gcs_src_t kind;

		assign ca = (K == 1) ? pin_n[2*G] :
			(K == 3) ? pin_p[2*G+1] : pin_p[2*G];
		assign cb = (K == 0 || K == 3) ? pin_n[2*G+1] :
			(K == 2) ? pin_n[2*G] : pin_p[2*G+1];
		// Only the PLL of this side is reachable from this line.
		assign cnt = pll_counter_out[G*`GCS_LPS +: `GCS_LPS];
		assign ia = st_q.lcfg[i][`GCS_LCFG_PLLA +: 3];
		assign ib = st_q.lcfg[i][`GCS_LCFG_PLLB +: 3];
		assign pa = (ia < 3'h5) ? cnt[ia] : 1'b0;
		assign pb = (ib < 3'h5) ? cnt[ib] : 1'b0;
		assign dyn_cur = pick(st_q.sel[i], ca, cb, pa, pb);
		assign dyn_new = pick(clk_select[2*i +: 2], ca, cb, pa, pb);
		assign dpi = dp_index(i);
		assign dpv = (dpi == `GCS_NO_DUAL_PURPOSE_CLOCK_PIN) ? 1'b0 :
			dual_purpose_clock_pin[dpi[1:0]];
		assign kind = gcs_src_t'(st_q.lcfg[i][`GCS_LCFG_KIND +: 2]);
		always_comb
		begin
			case (kind)
				GCS_SRC_DYN: src_v[i] = dyn_cur;
				GCS_SRC_DUAL_PURPOSE_CLOCK_PIN: src_v[i] = dpv;
				GCS_SRC_LOGIC: src_v[i] = logic_clk_src[i];
				default: src_v[i] = 1'b0;
			endcase
		end
		assign fall_v[i] = st_q.src_prev[i] & ~src_v[i];
		// Switching while both old and new sources are low cannot cut
		// a high phase short or start one part way through.
		assign quiet_v[i] = ~dyn_cur & ~dyn_new;
		assign line_pll_ok[i] = (kind == GCS_SRC_DYN);

		chk_sel_quiet: assert property (
			st_q.sel[i] != $past(st_q.sel[i]) |-> $past(quiet_v[i]))
			else $error("line select changed while a source was high");
		chk_line_off_low: assert property (
			$past(!st_q.en[i] || st_q.pdn[i]) |-> !global_clock_line[i])
			else $error("disabled or powered-down line was high");
		chk_line_follows: assert property (
			$past(st_q.en[i] && !st_q.pdn[i]) |->
			global_clock_line[i] == $past(src_v[i]))
			else $error("enabled line did not follow its source");
	end

	// PLL reference: both pins of the first pair on this side, the p pin of the second, or a cascade line.
	for (genvar g = 0; g < `GCS_NSIDE; g++)
	begin : g_pll
		localparam int NB = ((g + 1) % `GCS_NSIDE) * `GCS_LPS;
		logic [1:0] rs;
		logic casc;
		// A cascade only passes when the line's source may feed a PLL.
		assign casc = st_q.line[NB] & line_pll_ok[NB];
		assign rs = st_q.mansw[g] ? pll_clkswitch[2*g +: 2] :
			st_q.refsel[2*g +: 2];
		assign ref_v[g] = pick(rs, pin_p[2*g], pin_n[2*g], pin_p[2*g+1],
			casc);
	end

	always_comb
	begin
		logic [31:0] nv;
		logic [4:0] li;
		logic [4:0] ri;
		nv = 32'h0;
		li = 5'h0;
		ri = 5'h0;
		st_d = st_q;

		for (int i = 0; i < `GCS_NLINE; i++)
		begin
			st_d.src_prev[i] = src_v[i];
			if (fall_v[i])
				st_d.en[i] = clk_enable[i];
			if (quiet_v[i])
				st_d.sel[i] = clk_select[2*i +: 2];
			// The gate sits on the line alone; PLL counters keep running.
			st_d.line[i] = src_v[i] & st_q.en[i] &
				~st_q.pdn[i];
		end
		st_d.pll_ref = ref_v;

		if (s_axi_awvalid && s_axi_awready)
		begin
			st_d.aw_got = 1'b1;
			st_d.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			st_d.w_got = 1'b1;
			st_d.wdata = s_axi_wdata;
			st_d.wstrb = s_axi_wstrb;
		end
		if (st_q.aw_got && st_q.w_got && !st_q.bvalid)
		begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = `GCS_RESP_OKAY;
			li = st_q.waddr[6:2] - `GCS_LCFG_IDX0;
			// Configuration is frozen once user mode is entered.
			if (st_q.umode || st_q.waddr[1:0] != 2'h0)
				st_d.bresp = `GCS_RESP_SLVERR;
			else if (st_q.waddr == `GCS_OFS_CTRL)
			begin
				nv = merge(ctrl_word(st_q), st_q.wdata, st_q.wstrb);
				st_d.umode = nv[`GCS_CTRL_UMODE];
				st_d.diff = nv[`GCS_CTRL_DIFF +: 4];
				st_d.mansw = nv[`GCS_CTRL_MANSW +: 4];
				st_d.refsel = nv[`GCS_CTRL_REFSEL +: 8];
			end
			else if (st_q.waddr == `GCS_OFS_PDN)
			begin
				nv = merge({12'h0, st_q.pdn}, st_q.wdata, st_q.wstrb);
				st_d.pdn = nv[`GCS_NLINE-1:0];
			end
			else if (st_q.waddr >= `GCS_OFS_LCFG0 &&
				st_q.waddr <= `GCS_OFS_LCFG19)
			begin
				nv = merge({24'h0, st_q.lcfg[li]}, st_q.wdata,
					st_q.wstrb);
				st_d.lcfg[li] = nv[7:0];
			end
			else
				st_d.bresp = `GCS_RESP_SLVERR;
		end
		if (st_q.bvalid && s_axi_bready)
			st_d.bvalid = 1'b0;

		if (s_axi_arvalid && s_axi_arready)
		begin
			st_d.rvalid = 1'b1;
			st_d.rresp = `GCS_RESP_OKAY;
			st_d.rdata = 32'h0;
			ri = s_axi_araddr[6:2] - `GCS_LCFG_IDX0;
			if (s_axi_araddr[1:0] != 2'h0)
				st_d.rresp = `GCS_RESP_SLVERR;
			else if (s_axi_araddr == `GCS_OFS_CTRL)
				st_d.rdata = ctrl_word(st_q);
			else if (s_axi_araddr == `GCS_OFS_PDN)
				st_d.rdata = {12'h0, st_q.pdn};
			else if (s_axi_araddr == `GCS_OFS_STAT)
				st_d.rdata = {12'h0, st_q.en & ~st_q.pdn};
			else if (s_axi_araddr >= `GCS_OFS_LCFG0 &&
				s_axi_araddr <= `GCS_OFS_LCFG19)
				st_d.rdata = {24'h0, st_q.lcfg[ri]};
			else
				st_d.rresp = `GCS_RESP_SLVERR;
		end
		else if (st_q.rvalid && s_axi_rready)
			st_d.rvalid = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q <= '0;
			st_q.refsel <= `GCS_RST_REFSEL;
			st_q.pdn <= `GCS_RST_PDN;
			for (int i = 0; i < `GCS_NLINE; i++)
				st_q.lcfg[i] <= `GCS_RST_LCFG;
		end
		else
			st_q <= st_d;
	end

	assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
	assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = !st_q.rvalid;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign global_clock_line = st_q.line;
	assign pll_ref_clk = st_q.pll_ref;

	chk_en_on_fall: assert property (
		((st_q.en ^ $past(st_q.en)) & ~$past(fall_v)) == '0)
		else $error("line enable changed away from a falling edge");
	chk_cfg_locked: assert property (
		$past(st_q.umode) |-> $stable(st_q.lcfg) && $stable(st_q.pdn) &&
		$stable(st_q.refsel) && $stable(st_q.diff) && st_q.umode)
		else $error("static configuration changed in user mode");
	// Line 5 is the cascade candidate of the PLL on side 0.
	chk_pll_feed: assert property (
		!st_q.mansw[0] && st_q.refsel[1:0] == 2'h3 && !line_pll_ok[5]
		|=> !pll_ref_clk[0])
		else $error("static-source line passed on as a PLL reference");
	chk_pll_casc: assert property (
		!st_q.mansw[0] && st_q.refsel[1:0] == 2'h3 && line_pll_ok[5]
		|=> pll_ref_clk[0] == $past(global_clock_line[5]))
		else $error("PLL reference did not follow its cascade line");
	chk_ref_follows: assert property (
		st_q.mansw[0] && pll_clkswitch[1:0] == 2'h1 |=>
		pll_ref_clk[0] == $past(pin_n[0]))
		else $error("PLL reference did not follow manual switch");
	chk_wr_resp: assert property (
		st_q.aw_got && st_q.w_got && !st_q.bvalid |=> s_axi_bvalid)
		else $error("write response not given one cycle after data");
	chk_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before it was taken");
	chk_rd_resp: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response not given one cycle after address");
	chk_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read response dropped before it was taken");
	cov_user_mode: cover property (!st_q.umode ##1 st_q.umode);
	cov_gate_off: cover property (st_q.en[0] ##1 !st_q.en[0]);
	cov_sel_switch: cover property (st_q.sel[0] != $past(st_q.sel[0]));
	cov_cascade: cover property (st_q.refsel[1:0] == 2'h3 && pll_ref_clk[0]);
	cov_locked_wr: cover property (
		s_axi_bvalid && s_axi_bresp == `GCS_RESP_SLVERR && st_q.umode);
endmodule
`default_nettype wire

// ### logic/gcs_defs.svh
// Constants of the global clock line source select and gate block.
// Assumes inclusion by its bare name from the package and the design.
`ifndef GCS_DEFS_SVH
`define GCS_DEFS_SVH
`define GCS_NLINE 20
`define GCS_NSIDE 4
`define GCS_LPS 5
`define GCS_NPIN 8
`define GCS_SMALL_PINS 4
`define GCS_OFS_CTRL 8'h00
`define GCS_OFS_PDN 8'h04
`define GCS_OFS_STAT 8'h08
`define GCS_OFS_LCFG0 8'h10
`define GCS_OFS_LCFG19 8'h5c
`define GCS_LCFG_IDX0 5'h04
`define GCS_CTRL_UMODE 0
`define GCS_CTRL_DIFF 4
`define GCS_CTRL_MANSW 8
`define GCS_CTRL_REFSEL 16
`define GCS_LCFG_KIND 0
`define GCS_LCFG_PLLA 2
`define GCS_LCFG_PLLB 5
`define GCS_RST_LCFG 8'h20
`define GCS_RST_PDN 20'h00000
`define GCS_RST_REFSEL 8'h00
`define GCS_NO_DUAL_PURPOSE_CLOCK_PIN 3'h4
`define GCS_RESP_OKAY 2'h0
`define GCS_RESP_SLVERR 2'h2
`endif

// ### logic/gcs_pkg.sv
// Types of the global clock line source select and gate block.
// Assumes gcs_defs.svh is on the include path.
`default_nettype none
`include "gcs_defs.svh"
package gcs_pkg;
	typedef enum logic [1:0] {
		GCS_SRC_DYN = 2'h0,
		GCS_SRC_DUAL_PURPOSE_CLOCK_PIN = 2'h1,
		GCS_SRC_LOGIC = 2'h3
	} gcs_src_t;

	typedef struct packed {
		logic umode;
		logic [3:0] diff;
		logic [3:0] mansw;
		logic [7:0] refsel;
		logic [`GCS_NLINE-1:0] pdn;
		logic [`GCS_NLINE-1:0][7:0] lcfg;
		logic [`GCS_NLINE-1:0] en;
		logic [`GCS_NLINE-1:0][1:0] sel;
		logic [`GCS_NLINE-1:0] src_prev;
		logic [`GCS_NLINE-1:0] line;
		logic [`GCS_NSIDE-1:0] pll_ref;
		logic aw_got;
		logic w_got;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} gcs_state_t;
endpackage
`default_nettype wire

// ### sim/gcs_user_model.sv
// User-side model: clock sources, dynamic selects, enables, PLL switch.
// Assumes the bench sets requests; sources toggle only while run is high.
`timescale 1ns/100ps
`default_nettype none
module gcs_user_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic [59:0] src_req,
	input wire logic [39:0] sel_req,
	input wire logic [19:0] en_req,
	input wire logic [7:0] sw_req,
	output logic [59:0] src,
	output logic [39:0] sel,
	output logic [19:0] en,
	output logic [7:0] sw
);
	logic ph_q;
	// Sources stand still low outside a burst, as idle clocks do.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ph_q <= 1'b0;
			src <= '0;
			sel <= '0;
			en <= '0;
			sw <= '0;
		end
		else
		begin
			ph_q <= run && !ph_q;
			src <= (run && !ph_q) ? src_req : '0;
			sel <= sel_req;
			en <= en_req;
			sw <= sw_req;
		end
	end
endmodule
`default_nettype wire

// ### sim/tb_global_clock_source_select_gate.sv
// Self-checking bench of the clock line source select and gate block.
// Assumes sim/gcs_user_model.sv and the logic/ files are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "gcs_defs.svh"
module tb_global_clock_source_select_gate;
	import gcs_pkg::*;
	logic aclk, aresetn, run;
	logic [7:0] awaddr, araddr, sw_req, sw;
	logic [31:0] wdata, rdata;
	logic awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs;
	logic [59:0] src_req, src;
	logic [39:0] sel_req, sel;
	logic [19:0] en_req, en, gcl, pll_ok, seen, pdn;
	logic [3:0] pref, rseen, diff;
	logic [7:0] cfg [20];
	int fail_count, samples_checked, cyc;

	gcs_user_model partner (.aclk(aclk), .aresetn(aresetn), .run(run),
		.src_req(src_req), .sel_req(sel_req), .en_req(en_req),
		.sw_req(sw_req), .src(src), .sel(sel), .en(en), .sw(sw));

	gcs_clock_ctrl dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .ded_clk_p(src[7:0]), .ded_clk_n(src[15:8]),
		.dual_purpose_clock_pin(src[19:16]), .pll_counter_out(src[39:20]),
		.logic_clk_src(src[59:40]), .clk_select(sel), .clk_enable(en),
		.pll_clkswitch(sw), .global_clock_line(gcl), .line_pll_ok(pll_ok),
		.pll_ref_clk(pref));

	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		cyc = 0;
		forever
		begin
			@(posedge aclk);
			cyc++;
			if (cyc > 20000)
			begin
				fail_count++;
				complete_run();
			end
		end
	end

	task automatic chk(input logic [59:0] sv, input logic [59:0] ev,
		input string m);
		samples_checked++;
		if (sv !== ev)
		begin
			fail_count++;
			$display("BAD %0t %s seen %h want %h", $time, m, sv, ev);
		end
	endtask

	// Bus tasks are entered just after a rising edge; ready sampled there.
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		rs = bresp;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		chk(60'(rdata), 60'(d), "rdata");
		chk(60'(rresp), 60'(r), "rresp");
	endtask

	// Expected level of line i for one source pattern v.
	function automatic logic ln(int i, logic [7:0] c, logic [1:0] s,
		logic [59:0] v, logic [3:0] d);
		logic [7:0] p, n;
		logic [2:0] x;
		int g, k, e;
		p = v[7:0];
		for (int j = 0; j < 8; j++)
			n[j] = d[j/2] ? p[j] : v[8+j];
		g = i / 5;
		k = i % 5;
		e = 2 * g;
		x = s[0] ? c[7:5] : c[4:2];
		case (c[1:0])
			2'h1: return g < 2 ? v[16 + e + (k % 2 == 1 || k == 4)] : 1'b0;
			2'h3: return v[40 + i];
			2'h0:
				case (s)
					2'h0: return k == 1 ? n[e] : k == 3 ? p[e+1] : p[e];
					2'h1: return k == 0 || k == 3 ? n[e+1] : k == 2 ? n[e] : p[e+1];
					default: return x > 4 ? 1'b0 : v[20 + 5*g + x];
				endcase
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [3:0] rf(logic [59:0] v);
		return {v[6], v[4], v[2], v[0]};
	endfunction

	task automatic setcfg(input logic [1:0] kind);
		for (int i = 0; i < 20; i++)
		begin
			cfg[i] = {3'($urandom_range(7)), 3'($urandom_range(7)), kind};
			axw(`GCS_OFS_LCFG0 + 8'(4*i), {24'h0, cfg[i]});
			chk(60'(rs), 60'h0, "cfg");
		end
	endtask

	task automatic pulse(input logic [59:0] v, input logic [1:0] s,
		input logic [3:0] rx);
		logic [19:0] ex;
		src_req <= v;
		sel_req <= {20{s}};
		repeat (3) @(posedge aclk);
		for (int i = 0; i < 20; i++)
			ex[i] = ln(i, cfg[i], s, v, diff) & en_req[i] & ~pdn[i];
		run <= 1'b1;
		seen = '0;
		rseen = '0;
		for (int t = 0; t < 14; t++)
		begin
			@(posedge aclk);
			#1;
			if (t > 5)
			begin
				seen |= gcl;
				rseen |= pref;
			end
		end
		run <= 1'b0;
		chk(60'(seen), 60'(ex), "lines");
		chk(60'(rseen), 60'(rx), "pll ref");
		repeat (4) @(posedge aclk);
	endtask

	initial
	begin
		logic [59:0] v;
		aresetn = 1'b0;
		{run, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
		{src_req, sel_req, sw_req, pdn, diff} = '0;
		en_req = '1;
		void'($urandom(32'hac3f));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(`GCS_OFS_CTRL, 32'h0, `GCS_RESP_OKAY);
		rchk(`GCS_OFS_PDN, 32'h0, `GCS_RESP_OKAY);
		rchk(`GCS_OFS_LCFG0, 32'h20, `GCS_RESP_OKAY);
		rchk(`GCS_OFS_LCFG19, 32'h20, `GCS_RESP_OKAY);
		rchk(8'h60, 32'h0, `GCS_RESP_SLVERR);
		rchk(8'h12, 32'h0, `GCS_RESP_SLVERR);
		axw(`GCS_OFS_STAT, 32'h1);
		chk(60'(rs), 60'(`GCS_RESP_SLVERR), "stat write");
		$display("test registers done");
		setcfg(2'h0);
		chk(60'(pll_ok), 60'hfffff, "pll ok");
		for (int b = 0; b < 16; b++)
			for (int s = 0; s < 2; s++)
				pulse(60'h1 << b, 2'(s), rf(60'h1 << b));
		for (int c = 20; c < 40; c++)
			for (int s = 2; s < 4; s++)
				pulse(60'h1 << c, 2'(s), 4'h0);
		$display("test dynamic sources done");
		setcfg(2'h1);
		chk(60'(pll_ok), 60'h0, "pll ok");
		for (int d = 16; d < 20; d++)
			pulse(60'h1 << d, 2'($urandom), 4'h0);
		repeat (4)
		begin
			setcfg(2'($urandom));
			v = 60'({$urandom, $urandom});
			pulse(v, 2'($urandom), rf(v));
		end
		$display("test static sources done");
		setcfg(2'h0);
		pdn = 20'($urandom);
		en_req <= 20'($urandom);
		axw(`GCS_OFS_PDN, {12'h0, pdn});
		pulse(60'hffff, 2'h0, 4'hf);
		rchk(`GCS_OFS_STAT, {12'h0, en_req & ~pdn}, `GCS_RESP_OKAY);
		$display("test gating done");
		diff = 4'($urandom) & 4'he | 4'h2;
		sw_req <= 8'h01;
		axw(`GCS_OFS_CTRL, {20'h0, 4'h1, diff, 4'h0});
		pulse(60'hff, 2'h1, 4'he);
		$display("test differential done");
		axw(`GCS_OFS_CTRL, {8'h0, 8'h03, 8'h0, diff, 4'h0});
		pdn = '0;
		en_req <= '1;
		axw(`GCS_OFS_PDN, 32'h0);
		cfg[5] = 8'h01;
		axw(`GCS_OFS_LCFG0 + 8'h14, {24'h0, cfg[5]});
		pulse(60'h1 << 18, 2'h0, 4'h0);
		cfg[5] = 8'h00;
		axw(`GCS_OFS_LCFG0 + 8'h14, {24'h0, cfg[5]});
		chk(60'(pll_ok[5]), 60'h1, "cascade line");
		pulse(60'h1 << 2, 2'h0, 4'h3);
		$display("test cascade done");
		axw(`GCS_OFS_CTRL, 32'h1);
		axw(`GCS_OFS_PDN, {12'h0, ~pdn});
		chk(60'(rs), 60'(`GCS_RESP_SLVERR), "locked");
		rchk(`GCS_OFS_PDN, {12'h0, pdn}, `GCS_RESP_OKAY);
		$display("test lock done");
		complete_run();
	end
endmodule
`default_nettype wire
